//--- src/rts_map.svh
// What this block does
// - Host refuses memory loads while programming bit clear
// - Sleep bit set sleeps, cleared wakes channel
// - Wake from sleep loads ramp settings and fine scale
// - Ramp enable bit off keeps gain fixed
// - Soft trigger bit is one shared pulse
// - Soft trigger plus select bits pick channels
// - Sixteen bit hold-off delays slot and scale
// - Host keeps hold-off between two and FFFD
// - Sixty-four fourteen bit ramp gain words
// - Ramp length register holds steps minus one
// - Rest time register holds rest minus one
// - Host writes trigger high, then back low
// - Count one starts ramp down, last to first
// - Rest period, then ramp up first to last
// - Trigger pins one to three reach every channel
// - Two select bits choose hardware trigger pin
// - Trigger source pulses pin high two clocks
// - Pin held high keeps reloading hold-off count
// - Soft trigger ORed with selected pin trigger
// - Pin zero needs channel mask and bit six
// - Enabled pin zero feeds each enabled channel's multiplexer
// - Hard reset sleeps all four channels
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH
// Microport external addresses
`define RTS_EXT_DATA0 3'h0
`define RTS_EXT_DATA1 3'h1
`define RTS_EXT_DATA2 3'h2
`define RTS_EXT_DATA3 3'h3
`define RTS_EXT_SLEEP 3'h4
`define RTS_EXT_SYNC 3'h5
`define RTS_EXT_ALO 3'h6
`define RTS_EXT_AHI 3'h7
// Soft trigger bit inside the sync register
`define RTS_SYNC_TRIG_BIT 5
// Internal map: bit 11 selects channel space, bits 10:9 the channel
`define RTS_CHAN_SPACE_BIT 11
`define RTS_COMMON_ROUTE 12'h001
`define RTS_PIN0_ROUTE_BIT 6
`define RTS_OFF_FINE 9'h00E
`define RTS_OFF_HOLDOFF 9'h00F
`define RTS_OFF_RAMP_EN 9'h016
`define RTS_OFF_RAMP_LEN 9'h017
`define RTS_OFF_REST 9'h019
`define RTS_OFF_MEM_LO 9'h040
`define RTS_OFF_MEM_HI 9'h17F
// Field layouts and values
`define RTS_HOLD_SEL_LSB 16
`define RTS_UNITY_GAIN 14'h3FFF
`define RTS_SLEEP_RESET 4'hF
`define RTS_HOLD_MIN 16'h0001
`define RTS_HOLD_MAX 16'hFFFE
`endif

//--- src/rts_pkg.sv
package rts_pkg;
    // Time-slot sequencer of one channel
    typedef enum logic [1:0] {
        RTS_IDLE,
        RTS_DOWN,
        RTS_REST,
        RTS_UP
    } rts_slot_t;
    // Host command kinds
    typedef enum logic [2:0] {
        RTS_CMD_WRITE,
        RTS_CMD_READ,
        RTS_CMD_CTRL,
        RTS_CMD_SOFT,
        RTS_CMD_PIN
    } rts_cmd_t;
    typedef enum logic [1:0] {
        RTS_H_IDLE,
        RTS_H_RUN,
        RTS_H_FIN
    } rts_hstate_t;
endpackage

//--- src/rts_if.sv
`timescale 1ns/100ps
`default_nettype none
// Byte-wide microport plus the four trigger pins
interface rts_if;
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] trig_pin;
    modport dev (input wr, rd, addr, wdata, trig_pin, output rdata);
    modport host (output wr, rd, addr, wdata, trig_pin, input rdata);
endinterface
`default_nettype wire

//--- src/rts_dev.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "rts_map.svh"
module rts_dev #(
    parameter int CHANNELS = 4,
    parameter int MEM_WORDS = 64
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    rts_if.dev PORT,
    output logic [CHANNELS*14-1:0] CH_GAIN,
    output logic [CHANNELS*14-1:0] CH_SCALE,
    output logic [CHANNELS-1:0] CH_SLEEP,
    output logic [CHANNELS-1:0] CH_SLOT
);
    // Elaboration check: the decode below is fixed to four channels
    if (CHANNELS != 4 || MEM_WORDS != 64) begin : g_bad_size
        $error("rts_dev serves four channels of 64 words only");
    end

    // Microport staging and control registers
    logic [7:0] stage [1:3];
    logic [11:0] iaddr;
    logic [3:0] sleep;
    logic [3:0] programming_mode_bit;
    logic [7:0] sync_reg;
    logic [7:0] route;
    logic [7:0] rdata;
    logic [31:0] ch_rd [4];
    logic [3:0] pin_s1n, pin_s2n, pin_s3n, pin_lv;

    wire ext_wr = PORT.wr;
    wire int_wr = ext_wr && PORT.addr == `RTS_EXT_DATA0;
    wire [31:0] int_wdata = {stage[3], stage[2], stage[1], PORT.wdata};
    wire chan_space = iaddr[`RTS_CHAN_SPACE_BIT];
    wire [1:0] chan_sel = iaddr[10:9];
    wire [8:0] chan_off = iaddr[8:0];
    wire common_hit = !chan_space && iaddr == `RTS_COMMON_ROUTE;
    wire sync_wr = ext_wr && PORT.addr == `RTS_EXT_SYNC;
    wire soft_pulse = sync_wr && PORT.wdata[`RTS_SYNC_TRIG_BIT];
    wire [31:0] int_rd = chan_space ? ch_rd[chan_sel] :
                         common_hit ? {24'h00_0000, route} : 32'h0000_0000;

    // Byte of the internal word shown at an external data address
    function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                             input logic [1:0] b);
        pick_byte = w[b*8 +: 8];
    endfunction

    assign PORT.rdata = rdata;

    // Microport registers; an internal write commits on the data0 write
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            stage[1] <= 8'h00;
            stage[2] <= 8'h00;
            stage[3] <= 8'h00;
            iaddr <= 12'h000;
            sleep <= `RTS_SLEEP_RESET;
            programming_mode_bit <= 4'h0;
            sync_reg <= 8'h00;
            route <= 8'h00;
            rdata <= 8'h00;
        end else begin
            if (ext_wr) begin
                case (PORT.addr)
                    `RTS_EXT_DATA1: stage[1] <= PORT.wdata;
                    `RTS_EXT_DATA2: stage[2] <= PORT.wdata;
                    `RTS_EXT_DATA3: stage[3] <= PORT.wdata;
                    `RTS_EXT_SLEEP: {programming_mode_bit, sleep} <= PORT.wdata;
                    `RTS_EXT_SYNC: sync_reg <= PORT.wdata;
                    `RTS_EXT_ALO: iaddr[7:0] <= PORT.wdata;
                    `RTS_EXT_AHI: iaddr[11:8] <= PORT.wdata[3:0];
                    default: ;
                endcase
            end
            if (int_wr && common_hit) begin
                route <= int_wdata[7:0];
            end
            if (PORT.rd) begin
                case (PORT.addr)
                    `RTS_EXT_SLEEP: rdata <= {programming_mode_bit, sleep};
                    `RTS_EXT_SYNC: rdata <= sync_reg;
                    `RTS_EXT_ALO: rdata <= iaddr[7:0];
                    `RTS_EXT_AHI: rdata <= {4'h0, iaddr[11:8]};
                    default: rdata <= pick_byte(int_rd, PORT.addr[1:0]);
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // Trigger pins come from outside: three stages, accept on agreement
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin_s1n <= 4'h0;
            pin_s2n <= 4'h0;
            pin_s3n <= 4'h0;
            pin_lv <= 4'h0;
        end else begin
            pin_s1n <= PORT.trig_pin;
            pin_s2n <= pin_s1n;
            pin_s3n <= pin_s2n;
            for (int i = 0; i < 4; i++) begin
                if (pin_s2n[i] == pin_s3n[i]) begin
                    pin_lv[i] <= pin_s3n[i];
                end
            end
        end
    end

    // One time-slot controller per channel
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        logic [13:0] mem [MEM_WORDS];
        logic [17:0] holdoff;
        logic [13:0] fine;
        logic ramp_en;
        logic [5:0] ramp_len;
        logic [4:0] rest_len;
        logic act_en;
        logic [5:0] act_len;
        logic [4:0] act_rest;
        logic [13:0] act_fine;
        logic [15:0] cnt;
        logic [5:0] idx;
        logic [4:0] rc;
        logic sleep_q;
        logic [13:0] gain;
        rts_pkg::rts_slot_t state;

        wire here = chan_space && chan_sel == 2'(c);
        wire off_mem = chan_off >= `RTS_OFF_MEM_LO &&
                       chan_off <= `RTS_OFF_MEM_HI;
        wire [8:0] mem_rel = chan_off - `RTS_OFF_MEM_LO;
        wire [5:0] mem_idx = mem_rel[5:0];
        wire wr_here = int_wr && here;
        wire run = !sleep[c] && !programming_mode_bit[c];
        wire wake = sleep_q && !sleep[c];
        wire pin0 = pin_lv[0] && route[c] && route[`RTS_PIN0_ROUTE_BIT];
        wire [3:0] pins = {pin_lv[3:1], pin0};
        wire hw_trig = pins[holdoff[`RTS_HOLD_SEL_LSB +: 2]];
        wire soft_trig = soft_pulse && PORT.wdata[c];
        wire trig = soft_trig || hw_trig;
        wire begin_slot = cnt == 16'h0001 && !trig && run;

        always_comb begin
            case (chan_off)
                `RTS_OFF_FINE: ch_rd[c] = {18'h0_0000, fine};
                `RTS_OFF_HOLDOFF: ch_rd[c] = {14'h0000, holdoff};
                `RTS_OFF_RAMP_EN: ch_rd[c] = {31'h0000_0000, ramp_en};
                `RTS_OFF_RAMP_LEN: ch_rd[c] = {26'h000_0000, ramp_len};
                `RTS_OFF_REST: ch_rd[c] = {27'h000_0000, rest_len};
                default: ch_rd[c] = off_mem ? {18'h0_0000, mem[mem_idx]}
                                            : 32'h0000_0000;
            endcase
        end

        always_ff @(posedge SYS_CLK) begin
            if (wr_here && off_mem) begin
                mem[mem_idx] <= int_wdata[13:0];
            end
        end

        // Channel registers written through the indirect port
        always_ff @(posedge SYS_CLK or posedge RST) begin
            if (RST) begin
                holdoff <= 18'h0_0000;
                fine <= `RTS_UNITY_GAIN;
                ramp_en <= 1'b0;
                ramp_len <= 6'h00;
                rest_len <= 5'h00;
            end else if (wr_here) begin
                case (chan_off)
                    `RTS_OFF_FINE: fine <= int_wdata[13:0];
                    `RTS_OFF_HOLDOFF: holdoff <= int_wdata[17:0];
                    `RTS_OFF_RAMP_EN: ramp_en <= int_wdata[0];
                    `RTS_OFF_RAMP_LEN: ramp_len <= int_wdata[5:0];
                    `RTS_OFF_REST: rest_len <= int_wdata[4:0];
                    default: ;
                endcase
            end
        end

        // Hold-off counter; a held trigger keeps it at the start count
        always_ff @(posedge SYS_CLK or posedge RST) begin
            if (RST) begin
                cnt <= 16'h0000;
                sleep_q <= 1'b1;
            end else begin
                sleep_q <= sleep[c];
                if (trig) begin
                    cnt <= holdoff[15:0];
                end else if (cnt != 16'h0000) begin
                    cnt <= cnt - 16'h0001;
                end
            end
        end

        // Slot sequencer: ramp down, rest, ramp up
        always_ff @(posedge SYS_CLK or posedge RST) begin
            if (RST) begin
                state <= rts_pkg::RTS_IDLE;
                act_en <= 1'b0;
                act_len <= 6'h00;
                act_rest <= 5'h00;
                act_fine <= `RTS_UNITY_GAIN;
                idx <= 6'h00;
                rc <= 5'h00;
                gain <= `RTS_UNITY_GAIN;
            end else begin
                if (wake) begin
                    act_en <= ramp_en;
                    act_len <= ramp_len;
                    act_rest <= rest_len;
                    act_fine <= fine;
                end
                case (state)
                    rts_pkg::RTS_IDLE: begin
                        if (begin_slot) begin
                            act_fine <= fine;
                            act_en <= ramp_en;
                            act_len <= ramp_len;
                            act_rest <= rest_len;
                            idx <= ramp_len;
                            if (ramp_en) begin
                                state <= rts_pkg::RTS_DOWN;
                            end
                        end
                    end
                    rts_pkg::RTS_DOWN: begin
                        if (idx == 6'h00) begin
                            rc <= act_rest;
                            state <= rts_pkg::RTS_REST;
                        end else begin
                            idx <= idx - 6'h01;
                        end
                    end
                    rts_pkg::RTS_REST: begin
                        if (rc == 5'h00) begin
                            state <= rts_pkg::RTS_UP;
                        end else begin
                            rc <= rc - 5'h01;
                        end
                    end
                    rts_pkg::RTS_UP: begin
                        if (idx == act_len) begin
                            state <= rts_pkg::RTS_IDLE;
                        end else begin
                            idx <= idx + 6'h01;
                        end
                    end
                    default: state <= rts_pkg::RTS_IDLE;
                endcase
                if (!run) begin
                    state <= rts_pkg::RTS_IDLE;
                end
                if (state == rts_pkg::RTS_IDLE || !act_en) begin
                    gain <= `RTS_UNITY_GAIN;
                end else if (state == rts_pkg::RTS_REST) begin
                    gain <= mem[6'h00];
                end else begin
                    gain <= mem[idx];
                end
            end
        end

        assign CH_GAIN[c*14 +: 14] = gain;
        assign CH_SCALE[c*14 +: 14] = act_fine;
        assign CH_SLEEP[c] = sleep_q;
        assign CH_SLOT[c] = state != rts_pkg::RTS_IDLE;
    end
endmodule
`default_nettype wire

//--- src/rts_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "rts_map.svh"
module rts_host (
    input wire logic SYS_CLK,
    input wire logic RST,
    rts_if.host PORT,
    input wire logic USR_REQ,
    input wire rts_pkg::rts_cmd_t USR_KIND,
    input wire logic [11:0] USR_ADDR,
    input wire logic [31:0] USR_DATA,
    output logic USR_BUSY,
    output logic USR_DONE,
    output logic USR_ERR,
    output logic [31:0] USR_RDATA
);
    rts_pkg::rts_hstate_t state;
    rts_pkg::rts_cmd_t kind;
    logic [11:0] addr;
    logic [31:0] data;
    logic [2:0] step;
    logic [7:0] ctl_shadow;
    logic wr, rd;
    logic [2:0] pa;
    logic [7:0] pd;
    logic [3:0] pin;
    logic rd_q;

    // Microport operation for the current step
    logic op_wr, op_rd, op_last;
    logic [2:0] op_a;
    logic [7:0] op_d;
    always_comb begin
        op_wr = 1'b0;
        op_rd = 1'b0;
        op_a = `RTS_EXT_DATA0;
        op_d = 8'h00;
        op_last = 1'b0;
        case (kind)
            rts_pkg::RTS_CMD_WRITE, rts_pkg::RTS_CMD_READ: begin
                op_last = step == 3'd5;
                if (step == 3'd0) begin
                    op_wr = 1'b1;
                    op_a = `RTS_EXT_AHI;
                    op_d = {4'h0, addr[11:8]};
                end else if (step == 3'd1) begin
                    op_wr = 1'b1;
                    op_a = `RTS_EXT_ALO;
                    op_d = addr[7:0];
                end else begin
                    // Bytes go MSB first so data0 commits the word
                    op_wr = kind == rts_pkg::RTS_CMD_WRITE;
                    op_rd = kind == rts_pkg::RTS_CMD_READ;
                    op_a = 3'd5 - step;
                    op_d = data[(5 - step) * 8 +: 8];
                end
            end
            rts_pkg::RTS_CMD_CTRL: begin
                op_last = 1'b1;
                op_wr = 1'b1;
                op_a = `RTS_EXT_SLEEP;
                op_d = data[7:0];
            end
            rts_pkg::RTS_CMD_SOFT: begin
                op_last = step == 3'd1;
                op_wr = 1'b1;
                op_a = `RTS_EXT_SYNC;
                op_d = {2'b00, step == 3'd0, 1'b0, data[3:0]};
            end
            default: op_last = step == 3'd1;
        endcase
    end

    // Refusals: memory loads need programming mode, hold-off stays legal
    wire req_chan = USR_ADDR[`RTS_CHAN_SPACE_BIT];
    wire [8:0] req_off = USR_ADDR[8:0];
    wire req_mem = req_chan && req_off >= `RTS_OFF_MEM_LO &&
                   req_off <= `RTS_OFF_MEM_HI;
    wire req_hold = req_chan && req_off == `RTS_OFF_HOLDOFF;
    wire bad_programming_mode_bit = req_mem && !ctl_shadow[4 + USR_ADDR[10:9]];
    wire bad_hold = req_hold && (USR_DATA[15:0] <= `RTS_HOLD_MIN ||
                                 USR_DATA[15:0] >= `RTS_HOLD_MAX);
    wire refuse = USR_KIND == rts_pkg::RTS_CMD_WRITE && (bad_programming_mode_bit || bad_hold);

    assign PORT.wr = wr;
    assign PORT.rd = rd;
    assign PORT.addr = pa;
    assign PORT.wdata = pd;
    assign PORT.trig_pin = pin;

    // Command sequencer; one microport strobe per cycle
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state <= rts_pkg::RTS_H_IDLE;
            kind <= rts_pkg::RTS_CMD_WRITE;
            addr <= 12'h000;
            data <= 32'h0000_0000;
            step <= 3'd0;
            ctl_shadow <= {4'h0, `RTS_SLEEP_RESET};
            wr <= 1'b0;
            rd <= 1'b0;
            pa <= 3'd0;
            pd <= 8'h00;
            pin <= 4'h0;
            rd_q <= 1'b0;
            USR_BUSY <= 1'b0;
            USR_DONE <= 1'b0;
            USR_ERR <= 1'b0;
            USR_RDATA <= 32'h0000_0000;
        end else begin
            wr <= 1'b0;
            rd <= 1'b0;
            pin <= 4'h0;
            USR_DONE <= 1'b0;
            USR_ERR <= 1'b0;
            rd_q <= rd;
            if (rd_q) begin
                USR_RDATA <= {USR_RDATA[23:0], PORT.rdata};
            end
            case (state)
                rts_pkg::RTS_H_IDLE: begin
                    if (USR_REQ && refuse) begin
                        USR_ERR <= 1'b1;
                    end else if (USR_REQ) begin
                        kind <= USR_KIND;
                        addr <= USR_ADDR;
                        data <= USR_DATA;
                        step <= 3'd0;
                        USR_BUSY <= 1'b1;
                        state <= rts_pkg::RTS_H_RUN;
                    end
                end
                rts_pkg::RTS_H_RUN: begin
                    wr <= op_wr;
                    rd <= op_rd;
                    pa <= op_a;
                    pd <= op_d;
                    // two clock pulse, so the pin filter agrees
                    if (kind == rts_pkg::RTS_CMD_PIN) begin
                        pin[data[1:0]] <= 1'b1;
                    end
                    if (kind == rts_pkg::RTS_CMD_CTRL) begin
                        ctl_shadow <= data[7:0];
                    end
                    step <= step + 3'd1;
                    if (op_last) begin
                        state <= rts_pkg::RTS_H_FIN;
                    end
                end
                rts_pkg::RTS_H_FIN: begin
                    if (!rd_q) begin
                        USR_BUSY <= 1'b0;
                        USR_DONE <= 1'b1;
                        state <= rts_pkg::RTS_H_IDLE;
                    end
                end
                default: state <= rts_pkg::RTS_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- dv/rts_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the microport wires, all four sleep outputs and the channel 0 gain and slot outputs
module rts_monitor #(
    parameter int SLOT_CYC = 11,
    parameter logic [13:0] LAST_GAIN = 14'h0D00
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic wr,
    input wire logic rd,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [3:0] trig_pin,
    input wire logic [55:0] CH_GAIN,
    input wire logic [3:0] CH_SLEEP,
    input wire logic [3:0] CH_SLOT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic [7:0] run;
    // Slot length counter; a counter, since repetition stops at eight
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST)
            run <= 8'h00;
        else
            run <= CH_SLOT[0] ? run + 8'h01 : 8'h00;
    end
    AST_STROBE_ONE: assert property (!(wr && rd))
        else $error("write and read strobes high together");
    AST_RDATA_QUIET: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_SLEEP_FOLLOW: assert property (wr && addr == 3'h4 |->
        ##2 CH_SLEEP == $past(wdata[3:0], 2))
        else $error("sleep outputs do not follow register write");
    AST_PIN_PULSE: assert property ($rose(|trig_pin) |=>
        (|trig_pin) ##1 trig_pin == 4'h0)
        else $error("trigger pin pulse not two cycles long");
    AST_RESET_SLEEP: assert property ($past(RST) |-> CH_SLEEP == 4'hF)
        else $error("channels awake after reset");
    AST_SLOT_LEN: assert property ($fell(CH_SLOT[0]) |-> run == SLOT_CYC)
        else $error("slot length wrong");
    AST_FIRST_GAIN: assert property ($rose(CH_SLOT[0]) |->
        ##[0:1] CH_GAIN[13:0] == LAST_GAIN)
        else $error("ramp down does not start at last word");
    AST_GAIN_FIXED: assert property (!CH_SLOT[0] [*3] |->
        CH_GAIN[13:0] == 14'h3FFF)
        else $error("gain not unity outside a slot");
    // Main scenarios reached
    COV_READ: cover property (rd);
    COV_SLOT: cover property ($rose(CH_SLOT[0]));
    COV_WAKE: cover property ($fell(CH_SLEEP[0]));
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk;
    logic rst;
    logic req;
    rts_pkg::rts_cmd_t kind;
    logic [11:0] uaddr;
    logic [31:0] udata;
    logic done;
    logic busy;
    logic err;
    logic [31:0] rdat;
    logic [55:0] gain_o;
    logic [55:0] scale_o;
    logic [3:0] sleep_o;
    logic [3:0] slot_o;
    logic [13:0] scl;
    logic [11:0] ra [6];
    logic [31:0] rv [6];
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'hf9ec097f;
    int hold;
    int waited;
    rts_if rts_if_i ();
    rts_dev rts_dev_i (.SYS_CLK(clk), .RST(rst), .PORT(rts_if_i.dev),
        .CH_GAIN(gain_o), .CH_SCALE(scale_o), .CH_SLEEP(sleep_o),
        .CH_SLOT(slot_o));
    rts_host rts_host_i (.SYS_CLK(clk), .RST(rst), .PORT(rts_if_i.host),
        .USR_REQ(req), .USR_KIND(kind), .USR_ADDR(uaddr), .USR_DATA(udata),
        .USR_BUSY(busy), .USR_DONE(done), .USR_ERR(err), .USR_RDATA(rdat));
    rts_monitor rts_monitor_i (.SYS_CLK(clk), .RST(rst), .wr(rts_if_i.wr),
        .rd(rts_if_i.rd), .addr(rts_if_i.addr), .wdata(rts_if_i.wdata),
        .rdata(rts_if_i.rdata), .trig_pin(rts_if_i.trig_pin),
        .CH_GAIN(gain_o), .CH_SLEEP(sleep_o), .CH_SLOT(slot_o));
    // Free running 100 MHz clock
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Hang guard, far above the under two thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Ramp word of index i, distinct and never unity
    function automatic logic [13:0] gain(input int i);
        return 14'(i * 1024 + 256);
    endfunction
    // One user command; waits for done or refusal under a bound
    task automatic cmd(input rts_pkg::rts_cmd_t k, input logic [11:0] a,
        input logic [31:0] d, input logic eerr);
        logic e;
        req <= 1;
        kind <= k;
        uaddr <= a;
        udata <= d;
        @(posedge clk);
        req <= 0;
        @(posedge clk);
        chk("usr_busy", !eerr, busy);
        for (int n = 0; n < 50 && done !== 1'b1 && err !== 1'b1; n++)
            @(posedge clk);
        e = err;
        chk("usr_err", eerr, e);
        @(posedge clk);
    endtask
    // Waits for a slot on channel 0 and checks its gain path
    task automatic slot(input logic exp);
        logic [13:0] q[$];
        logic got;
        got = 0;
        waited = 0;
        while (waited < 200 && got !== 1'b1) begin
            @(posedge clk);
            waited++;
            got = slot_o[0];
        end
        chk("slot_seen", exp, got);
        if (got === 1'b1) begin
            for (int n = 0; n < 30; n++) begin
                if (gain_o[13:0] !== 14'h3FFF &&
                    (q.size() == 0 || q[$] !== gain_o[13:0]))
                    q.push_back(gain_o[13:0]);
                @(posedge clk);
            end
            chk("ramp_steps", 7, q.size());
            for (int n = 0; n < 7; n++)
                chk("ramp_gain", gain(n < 4 ? 3 - n : n - 3), q[n]);
        end
    endtask
    // Main sequence on channel 0, ramp of four words and rest of three
    initial begin
        rst = 1;
        req = 0;
        kind = rts_pkg::RTS_CMD_WRITE;
        uaddr = 12'h000;
        udata = 32'h0000_0000;
        hold = 3 + ($random(seed) & 32'h0000_003F);
        scl = 14'($random(seed));
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        chk("sleep_reset", 4'hF, sleep_o);
        cmd(rts_pkg::RTS_CMD_CTRL, 12'h000, 32'h0000_001F, 0);
        for (int i = 0; i < 4; i++)
            cmd(rts_pkg::RTS_CMD_WRITE, 12'h840 + 12'(i), gain(i), 0);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'hA40, 32'h0000_0000, 1);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h80F,
            {14'h0000, 2'h1, hold[15:0]}, 0);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h80F, 32'h0000_0001, 1);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h816, 32'h0000_0001, 0);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h817, 32'h0000_0003, 0);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h819, 32'h0000_0002, 0);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h80E, {18'h0_0000, scl}, 0);
        ra = '{12'h80F, 12'h816, 12'h817, 12'h819, 12'h843, 12'h0F0};
        rv = '{{14'h0000, 2'h1, hold[15:0]}, 32'h1, 32'h3, 32'h2,
            {18'h0_0000, gain(3)}, 32'h0};
        for (int i = 0; i < 6; i++) begin
            cmd(rts_pkg::RTS_CMD_READ, ra[i], 32'h0000_0000, 0);
            chk("readback", rv[i], rdat);
        end
        cmd(rts_pkg::RTS_CMD_CTRL, 12'h000, 32'h0000_0000, 0);
        chk("wake", 1'b0, sleep_o[0]);
        chk("scale_on_wake", scl, scale_o[13:0]);
        cmd(rts_pkg::RTS_CMD_SOFT, 12'h000, 32'h0000_0001, 0);
        slot(1);
        chk("holdoff", hold - 2, waited);
        cmd(rts_pkg::RTS_CMD_SOFT, 12'h000, 32'h0000_0002, 0);
        slot(0);
        // Pins one to three in turn, selected through the hold-off register
        for (int p = 1; p < 4; p++) begin
            cmd(rts_pkg::RTS_CMD_WRITE, 12'h80F,
                {14'h0000, 2'(p), hold[15:0]}, 0);
            cmd(rts_pkg::RTS_CMD_PIN, 12'h000, 32'(p), 0);
            slot(1);
        end
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h80F, {16'h0000, hold[15:0]}, 0);
        // Pin zero passes only with channel bit and route bit both set
        for (int i = 0; i < 3; i++) begin
            cmd(rts_pkg::RTS_CMD_WRITE, 12'h001,
                i == 0 ? 32'h40 : i == 1 ? 32'h01 : 32'h41, 0);
            cmd(rts_pkg::RTS_CMD_PIN, 12'h000, 32'h0000_0000, 0);
            slot(i == 2);
        end
        // New fine scale waits for the slot start, even with ramp off
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h80E, {18'h0_0000, ~scl}, 0);
        chk("scale_held", scl, scale_o[13:0]);
        cmd(rts_pkg::RTS_CMD_WRITE, 12'h816, 32'h0000_0000, 0);
        cmd(rts_pkg::RTS_CMD_SOFT, 12'h000, 32'h0000_0001, 0);
        slot(0);
        chk("scale_at_slot", {18'h0_0000, ~scl}, scale_o[13:0]);
        report_and_stop();
    end
endmodule
`default_nettype wire
